/* File: core/hmt_pkg.sv */
// Package: offsets, layouts and timing for the monitor error and temperature bank
package hmt_pkg;
   // Register offsets
   localparam logic [7:0] CPU2_THROTTLE_ERROR_STATUS_OFS = 8'h4D;
   localparam logic [7:0] INPUT_PIN_ERROR_STATUS_OFS = 8'h4E;
   localparam logic [7:0] FAN_TACH_ERROR_STATUS_OFS = 8'h4F;
   localparam logic [7:0] ZONE1_TEMPERATURE_OFS = 8'h50;
   localparam logic [7:0] ZONE2_TEMPERATURE_OFS = 8'h51;
   localparam logic [7:0] ZONE3_INTERNAL_TEMPERATURE_OFS = 8'h52;
   localparam logic [7:0] ZONE4_EXTERNAL_TEMPERATURE_OFS = 8'h53;
   localparam logic [7:0] ZONE1_FILTERED_TEMPERATURE_OFS = 8'h54;
   localparam logic [7:0] ZONE2_FILTERED_TEMPERATURE_OFS = 8'h55;

   // Reset values
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] TEMP_RESET = 8'h00;
   localparam logic [7:0] FILTERED_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // Diode fault reading
   localparam logic [7:0] DIODE_FAULT_CODE = 8'h80;

   // Throttle status bit positions
   localparam int ANY_THROTTLE_BIT = 0;
   localparam int BIN1_BIT = 1;
   localparam int BIN2_BIT = 2;
   localparam int BIN3_BIT = 3;
   localparam int BIN4_BIT = 4;
   localparam int BIN5_BIT = 5;
   localparam int FULL_THROTTLE_BIT = 6;
   localparam int LIMIT_ERROR_BIT = 7;

   // Fan status layout: bits 2:0 clearable, bit 3 read-only, 7:4 reserved
   localparam logic [7:0] FAN_CLEARABLE_MASK = 8'h07;
   localparam logic [7:0] FAN_IMPLEMENTED_MASK = 8'h0F;

   // Throttle fraction thresholds on a 0..255 scale (255 = whole interval)
   localparam logic [7:0] FRAC_ONE_EIGHTH = 8'h20;
   localparam logic [7:0] FRAC_ONE_QUARTER = 8'h40;
   localparam logic [7:0] FRAC_ONE_HALF = 8'h80;
   localparam logic [7:0] FRAC_THREE_QUARTERS = 8'hC0;
   localparam logic [7:0] FRAC_FULL = 8'hFF;

   // Throttle sampling timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int THROTTLE_SAMPLE_NS = 10000;
   localparam int THROTTLE_SAMPLE_CYCLES =
      (THROTTLE_SAMPLE_NS / CLK_PERIOD_NS < 1) ? 1 : THROTTLE_SAMPLE_NS / CLK_PERIOD_NS;
   localparam logic [7:0] SAMPLES_PER_INTERVAL = 8'hFF;

   // Sleep states
   typedef enum logic [1:0] {
      HMT_S0 = 2'b00,
      HMT_S1 = 2'b01,
      HMT_S3 = 2'b10,
      HMT_S45 = 2'b11
   } hmt_sleep_e;

   // Temperature measurements from the converter
   typedef struct packed {
      logic [7:0] zone1;
      logic [7:0] zone2;
      logic [7:0] zone3;
      logic valid;
      logic diode1_fault;
      logic diode2_fault;
   } hmt_temp_in_s;

   // Tach counts and limits, one 16-bit word per channel
   typedef struct packed {
      logic [3:0][15:0] count;
      logic [3:0][15:0] limit;
   } hmt_fan_in_s;

   // Spike smoothing control: enable and shift depth for zones 1 and 2
   typedef struct packed {
      logic z1_enable;
      logic [2:0] z1_shift;
      logic z2_enable;
      logic [2:0] z2_shift;
   } hmt_smooth_s;
endpackage : hmt_pkg

/* File: core/hmt_regs.sv */
// Error status and temperature value register bank of the hardware monitor
`timescale 1ns/10ps
module hmt_regs
   import hmt_pkg::*;
#(
   parameter int SAMPLE_CYCLES = THROTTLE_SAMPLE_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Register access from the serial interface engine
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_wr_data,
   input wire logic reg_rd_en,
   output logic [7:0] reg_rd_data,
   // Pins
   input wire logic cpu2_throttle_input,
   input wire logic [7:0] general_pin,
   // Settings held elsewhere in the device
   input wire logic [7:0] throttle_limit,
   input wire logic [7:0] input_error_mask,
   input wire hmt_smooth_s smooth_ctrl,
   input wire hmt_sleep_e sleep_state,
   // Measurements
   input wire hmt_temp_in_s temp_in,
   input wire hmt_fan_in_s fan_in,
   // Summary
   output logic host_error
);

   // Pin synchronisers, two stages each
   logic thr_meta_reg;
   logic thr_sync_reg;
   logic [7:0] pin_meta_reg;
   logic [7:0] pin_sync_reg;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         thr_meta_reg <= 1'b0;
         thr_sync_reg <= 1'b0;
         pin_meta_reg <= 8'hFF;
         pin_sync_reg <= 8'hFF;
      end else begin
         thr_meta_reg <= cpu2_throttle_input;
         thr_sync_reg <= thr_meta_reg;
         pin_meta_reg <= general_pin;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // Sample tick divider
   logic [15:0] div_reg;
   wire sample_tick = (div_reg == 16'(SAMPLE_CYCLES - 1));

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         div_reg <= 16'h0000;
      end else begin
         div_reg <= sample_tick ? 16'h0000 : div_reg + 16'h0001;
      end
   end

   // Throttle duty measurement over 255 samples; count 255 means whole interval
   logic [7:0] samp_idx_reg;
   logic [7:0] hot_cnt_reg;
   logic [7:0] meas_reg;
   logic meas_done_reg;
   wire last_sample = (samp_idx_reg == SAMPLES_PER_INTERVAL - 8'h01);
   wire [7:0] hot_cnt_next = hot_cnt_reg + {7'h00, thr_sync_reg};

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         samp_idx_reg <= 8'h00;
         hot_cnt_reg <= 8'h00;
         meas_reg <= 8'h00;
         meas_done_reg <= 1'b0;
      end else begin
         meas_done_reg <= sample_tick && last_sample;
         if (sample_tick) begin
            if (last_sample) begin
               meas_reg <= hot_cnt_next;
               samp_idx_reg <= 8'h00;
               hot_cnt_reg <= 8'h00;
            end else begin
               samp_idx_reg <= samp_idx_reg + 8'h01;
               hot_cnt_reg <= hot_cnt_next;
            end
         end
      end
   end

   // Bin decode of the finished measurement
   wire thr_any = (meas_reg != 8'h00);
   wire thr_bin1 = thr_any && (meas_reg < FRAC_ONE_EIGHTH);
   wire thr_bin2 = (meas_reg >= FRAC_ONE_EIGHTH) && (meas_reg < FRAC_ONE_QUARTER);
   wire thr_bin3 = (meas_reg >= FRAC_ONE_QUARTER) && (meas_reg < FRAC_ONE_HALF);
   wire thr_bin4 = (meas_reg >= FRAC_ONE_HALF) && (meas_reg < FRAC_THREE_QUARTERS);
   wire thr_bin5 = (meas_reg >= FRAC_THREE_QUARTERS) && (meas_reg < FRAC_FULL);
   wire thr_full = (meas_reg == FRAC_FULL);
   wire thr_limit = (meas_reg > throttle_limit);
   wire [7:0] thr_events = {thr_limit, thr_full, thr_bin5, thr_bin4,
                            thr_bin3, thr_bin2, thr_bin1, thr_any};

   // Sleep masking per register group
   wire sleep_s1 = (sleep_state == HMT_S1);
   wire sleep_deep = (sleep_state == HMT_S3) || (sleep_state == HMT_S45);
   wire thr_allowed = !sleep_deep;
   wire pin_allowed = !(sleep_deep || sleep_s1);
   wire fan_allowed = !(sleep_deep || sleep_s1);

   // Event set vectors, gated by sleep
   wire [7:0] thr_set = (meas_done_reg && thr_allowed) ? thr_events : 8'h00;
   wire [7:0] pin_set = pin_allowed ? (~pin_sync_reg & ~input_error_mask) : 8'h00;
   logic [3:0] fan_over;

   // One comparator per tach channel
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_fan
         assign fan_over[gi] = fan_in.count[gi] > fan_in.limit[gi];
      end
   endgenerate

   wire [7:0] fan_set = fan_allowed ? {4'h0, fan_over} : 8'h00;

   // Register decode
   wire wr_thr = reg_wr_en && (reg_addr == CPU2_THROTTLE_ERROR_STATUS_OFS);
   wire wr_pin = reg_wr_en && (reg_addr == INPUT_PIN_ERROR_STATUS_OFS);
   wire wr_fan = reg_wr_en && (reg_addr == FAN_TACH_ERROR_STATUS_OFS);
   wire wr_zone4 = reg_wr_en && (reg_addr == ZONE4_EXTERNAL_TEMPERATURE_OFS);

   // Sticky write-one-to-clear update; a same-cycle set beats the clear
   function automatic logic [7:0] sticky(input logic [7:0] cur, input logic [7:0] set,
                                         input logic [7:0] clr);
      sticky = (cur & ~clr) | set;
   endfunction : sticky

   logic [7:0] thr_stat_reg;
   logic [7:0] pin_stat_reg;
   logic [7:0] fan_stat_reg;
   wire [7:0] thr_stat_next = sticky(thr_stat_reg, thr_set, wr_thr ? reg_wr_data : 8'h00);
   wire [7:0] pin_stat_next = sticky(pin_stat_reg, pin_set, wr_pin ? reg_wr_data : 8'h00);
   // Fan 4 and reserved bits ignore clear writes
   wire [7:0] fan_clr = wr_fan ? (reg_wr_data & FAN_CLEARABLE_MASK) : 8'h00;
   wire [7:0] fan_stat_next =
      sticky(fan_stat_reg, fan_set, fan_clr) & FAN_IMPLEMENTED_MASK;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         thr_stat_reg <= STATUS_RESET;
         pin_stat_reg <= STATUS_RESET;
         fan_stat_reg <= STATUS_RESET;
      end else begin
         thr_stat_reg <= thr_stat_next;
         pin_stat_reg <= pin_stat_next;
         fan_stat_reg <= fan_stat_next;
      end
   end

   // Summary: only the limit error reaches the host error output
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         host_error <= 1'b0;
      end else begin
         host_error <= thr_stat_next[LIMIT_ERROR_BIT];
      end
   end

   // Unfiltered zone readings, substituted on diode fault
   wire [7:0] z1_value = temp_in.diode1_fault ? DIODE_FAULT_CODE : temp_in.zone1;
   wire [7:0] z2_value = temp_in.diode2_fault ? DIODE_FAULT_CODE : temp_in.zone2;

   // Spike smoothing: first-order low pass, step scaled down by 2^shift
   function automatic logic [7:0] smooth(input logic [7:0] prev, input logic [7:0] raw,
                                         input logic en, input logic [2:0] sh);
      logic signed [8:0] diff;
      logic signed [8:0] step;
      diff = $signed({1'b0, raw}) - $signed({1'b0, prev});
      step = diff >>> sh;
      if (!en) begin
         smooth = raw;
      end else if (step == 9'sd0) begin
         // Keep creeping so the filter can settle on the raw value
         smooth = (diff > 9'sd0) ? prev + 8'h01 : (diff < 9'sd0) ? prev - 8'h01 : prev;
      end else begin
         smooth = 8'($signed({1'b0, prev}) + step);
      end
   endfunction : smooth

   wire [7:0] z1_filt_next;
   wire [7:0] z2_filt_next;
   logic [7:0] z1_reg;
   logic [7:0] z2_reg;
   logic [7:0] z3_reg;
   logic [7:0] z4_reg;
   logic [7:0] z1_filt_reg;
   logic [7:0] z2_filt_reg;

   assign z1_filt_next = smooth(z1_filt_reg, z1_value, smooth_ctrl.z1_enable,
                                smooth_ctrl.z1_shift);
   assign z2_filt_next = smooth(z2_filt_reg, z2_value, smooth_ctrl.z2_enable,
                                smooth_ctrl.z2_shift);

   // Zone 1 to 3 and filtered temperature registers follow each conversion result
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         z1_reg <= TEMP_RESET;
         z2_reg <= TEMP_RESET;
         z3_reg <= TEMP_RESET;
         z1_filt_reg <= FILTERED_RESET;
         z2_filt_reg <= FILTERED_RESET;
      end else if (temp_in.valid) begin
         z1_reg <= z1_value;
         z2_reg <= z2_value;
         z3_reg <= temp_in.zone3;
         z1_filt_reg <= z1_filt_next;
         z2_filt_reg <= z2_filt_next;
      end
   end

   // Zone 4 has no sensor; the host supplies the value
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         z4_reg <= TEMP_RESET;
      end else if (wr_zone4) begin
         z4_reg <= reg_wr_data;
      end
   end

   // Read mux; unmapped offsets return zero
   logic [7:0] rd_mux;

   always_comb begin
      unique case (reg_addr)
         CPU2_THROTTLE_ERROR_STATUS_OFS: rd_mux = thr_stat_reg;
         INPUT_PIN_ERROR_STATUS_OFS: rd_mux = pin_stat_reg;
         FAN_TACH_ERROR_STATUS_OFS: rd_mux = fan_stat_reg;
         ZONE1_TEMPERATURE_OFS: rd_mux = z1_reg;
         ZONE2_TEMPERATURE_OFS: rd_mux = z2_reg;
         ZONE3_INTERNAL_TEMPERATURE_OFS: rd_mux = z3_reg;
         ZONE4_EXTERNAL_TEMPERATURE_OFS: rd_mux = z4_reg;
         ZONE1_FILTERED_TEMPERATURE_OFS: rd_mux = z1_filt_reg;
         ZONE2_FILTERED_TEMPERATURE_OFS: rd_mux = z2_filt_reg;
         default: rd_mux = UNMAPPED_READ;
      endcase
   end

   // Read data captured on the read strobe, held until the next one
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         reg_rd_data <= UNMAPPED_READ;
      end else if (reg_rd_en) begin
         reg_rd_data <= rd_mux;
      end
   end

endmodule : hmt_regs

/* File: tb/hmt_regs_chk.sv */
// Checker: port assertions for the error and temperature bank
`timescale 1ns/10ps
module hmt_regs_chk
   import hmt_pkg::*;
#(
   parameter int SAMPLE_CYCLES = 1
) (
   // Clock, reset, register port
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_wr_data,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_rd_data,
   // Pins, settings, measurements
   input wire logic cpu2_throttle_input,
   input wire logic [7:0] general_pin,
   input wire logic [7:0] throttle_limit,
   input wire logic [7:0] input_error_mask,
   input wire hmt_smooth_s smooth_ctrl,
   input wire hmt_sleep_e sleep_state,
   input wire hmt_temp_in_s temp_in,
   input wire hmt_fan_in_s fan_in,
   input wire logic host_error
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Plain reads only; a read beside a write is left out
   wire logic [7:0] ra = (reg_rd_en && !reg_wr_en) ? reg_addr : 8'hFF;
   wire logic vld = temp_in.valid;
   wire logic s0 = sleep_state == HMT_S0;

   a_fan_reserved: assert property (
      ra == 8'h4F |=> reg_rd_data[7:4] == 4'h0) else $error("fan reserved bits set");
   a_fan_sets: assert property (
      (fan_in.count[0] > fan_in.limit[0] && s0)[*2] ##1 ra == 8'h4F |=> reg_rd_data[0])
      else $error("fan 1 error missing");
   a_pin_sets: assert property (
      (!general_pin[0] && !input_error_mask[0] && s0)[*4] ##1 ra == 8'h4E |=> reg_rd_data[0])
      else $error("pin 0 error missing");
   a_diode_code: assert property (
      vld && temp_in.diode1_fault ##1 !vld[*4] ##1 ra == 8'h50 |=> reg_rd_data == 8'h80)
      else $error("zone 1 fault code missing");
   a_zone3_load: assert property (
      vld ##1 !vld[*8] ##1 ra == 8'h52 |=> reg_rd_data == $past(temp_in.zone3, 10))
      else $error("zone 3 not loaded");
   a_filter_bypass: assert property (
      vld && !smooth_ctrl.z1_enable && !temp_in.diode1_fault ##1 ra == 8'h54
      |=> reg_rd_data == $past(temp_in.zone1, 2)) else $error("filtered zone 1 wrong");
   a_zone4_keeps: assert property (
      reg_wr_en && reg_addr == 8'h53 ##1 !(reg_wr_en && reg_addr == 8'h53) ##1 ra == 8'h53
      |=> reg_rd_data == $past(reg_wr_data, 3))
      else $error("zone 4 lost its value");
   a_summary_bit: assert property (
      ra == 8'h4D |=> reg_rd_data[7] == $past(host_error)) else $error("summary differs");
   a_summary_clear: assert property (
      $fell(host_error) && $past(reset_n) |-> $past(reg_wr_en) && $past(reg_addr) == 8'h4D
      && $past(reg_wr_data[7])) else $error("summary fell without a clear");
   // Main scenarios reached
   c_summary_drop: cover property ($fell(host_error));
   c_diode2: cover property (vld && temp_in.diode2_fault);
   c_fan_clear: cover property (reg_wr_en && reg_addr == 8'h4F);
endmodule : hmt_regs_chk

/* File: tb/hmt_host.sv */
// Host model: byte reads and writes on the bank's strobe port
`timescale 1ns/10ps
module hmt_host (
   // Clock
   input wire logic clk,
   // Strobes toward the bank
   output logic [7:0] reg_addr,
   output logic reg_wr_en,
   output logic [7:0] reg_wr_data,
   output logic reg_rd_en,
   input wire logic [7:0] reg_rd_data
);
   initial begin
      reg_addr = 8'h00;
      reg_wr_en = 1'b0;
      reg_wr_data = 8'h00;
      reg_rd_en = 1'b0;
   end
   // One write; an idle cycle after it so strobes never re-raise in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wr_data = d;
      reg_wr_en = 1'b1; // Zone 4 is filled from this side
      @(posedge clk);
      #1 reg_wr_en = 1'b0;
      reg_wr_data = ~d; // Released data does not keep the byte
      @(posedge clk);
      #1;
   endtask : wr
   // One read; data taken a cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      reg_addr = a;
      reg_rd_en = 1'b1;
      @(posedge clk);
      #1 d = reg_rd_data;
      reg_rd_en = 1'b0;
      @(posedge clk);
      #1;
   endtask : rd
endmodule : hmt_host

/* File: tb/testbench.sv */
// Testbench: random and corner traffic through the host model
`timescale 1ns/10ps
`define chk(g, e) \
   begin \
      samples_checked++; \
      if ((g) !== (e)) begin \
         n_errors++; \
         $display("BAD %0t got %h exp %h", $time, (g), (e)); \
      end \
   end
module testbench;
   import hmt_pkg::*;
   localparam int KT[7] = '{1, 3, 6, 10, 14, 16, 16};
   localparam logic [7:0] TOFS[5] = '{8'h54, 8'h55, 8'h50, 8'h51, 8'h52};
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
   logic reg_wr_en, reg_rd_en, host_error;
   logic thr = 1'b0;
   logic [7:0] general_pin = 8'hFF, throttle_limit = 8'h00, input_error_mask = 8'h00;
   hmt_smooth_s smooth_ctrl = '0;
   hmt_sleep_e sleep_state = HMT_S0;
   hmt_temp_in_s temp_in = '0;
   hmt_fan_in_s fan_in = '0;
   int n_errors = 0, samples_checked = 0, cycles = 0, duty = 0;
   logic [31:0] seed = 32'd61029;
   logic [3:0] ph = 4'h0;

   always #50 clk = ~clk;

   hmt_regs #(.SAMPLE_CYCLES(1)) u_hmt_regs (.clk(clk), .reset_n(reset_n),
      .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
      .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .cpu2_throttle_input(thr),
      .general_pin(general_pin), .throttle_limit(throttle_limit),
      .input_error_mask(input_error_mask), .smooth_ctrl(smooth_ctrl),
      .sleep_state(sleep_state), .temp_in(temp_in), .fan_in(fan_in), .host_error(host_error));
   hmt_host u_hmt_host (.clk(clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
      .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data));

   // Throttle duty out of 16, so the fraction holds whatever the interval phase
   always @(posedge clk) begin
      #1 ph = ph + 4'h1;
      thr = int'(ph) < duty;
   end
   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         n_errors++;
         print_verdict();
      end
   end

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task automatic print_verdict();
      if (n_errors == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : print_verdict
   // Flags expected for a measured count c out of 255
   function automatic logic [7:0] thr_exp(input int c, input logic [7:0] lim);
      return {c > lim, c == 255, c > 191 && c < 255, c > 127 && c < 192,
         c > 63 && c < 128, c > 31 && c < 64, c > 0 && c < 32, c > 0};
   endfunction : thr_exp
   // Smoothing: move by the shifted gap, at least one count
   function automatic logic [7:0] smooth(input logic [7:0] f, r, input logic [2:0] sh);
      int d, s;
      d = int'(r) - int'(f);
      s = d >>> sh;
      if (s == 0 && d != 0)
         s = (d > 0) ? 1 : -1;
      return 8'(int'(f) + s);
   endfunction : smooth

   initial begin
      logic [7:0] v, w, m, p, e, r1, r2, f1, f2, fexp;
      logic [7:0] ex[5];
      int c;
      step(6);
      reset_n = 1'b1;
      // Reset values, with an unmapped offset at each end
      for (int a = 8'h4C; a <= 8'h56; a++) begin
         u_hmt_host.rd(8'(a), v);
         `chk(v, 8'h00)
      end
      // Throttle bins; clear after the mixed interval, judge a pure one
      for (int i = 0; i < 7; i++) begin
         c = 255 * KT[i] / 16;
         w = 8'(xs());
         throttle_limit = (c - int'(w) < 4 && int'(w) - c < 4) ? w ^ 8'h80 : w;
         if (i == 5)
            throttle_limit = 8'hFF;
         // Light sleep must not hide throttle flags; deep sleep must
         sleep_state = (i == 6) ? HMT_S3 : (i == 4) ? HMT_S1 : HMT_S0;
         duty = KT[i];
         step(300);
         u_hmt_host.wr(8'h4D, 8'hFF);
         step(300);
         u_hmt_host.rd(8'h4D, v);
         e = (i == 6) ? 8'h00 : thr_exp(c, throttle_limit);
         `chk(v, e)
         `chk(host_error, e[7])
      end
      duty = 0;
      sleep_state = HMT_S0;
      step(300);
      u_hmt_host.wr(8'h4D, 8'hFF);
      // Pin errors; the last pass sleeps lightly
      for (int i = 0; i < 4; i++) begin
         p = (i == 0) ? 8'h00 : 8'(xs());
         m = 8'(xs()) & ((i == 0) ? 8'hF0 : 8'hFF);
         sleep_state = (i == 3) ? HMT_S1 : HMT_S0;
         input_error_mask = m;
         general_pin = p;
         step(5);
         u_hmt_host.rd(8'h4E, v);
         e = (i == 3) ? 8'h00 : ~p & ~m;
         `chk(v, e)
         general_pin = 8'hFF;
         step(4);
         w = 8'(xs());
         u_hmt_host.wr(8'h4E, w);
         u_hmt_host.rd(8'h4E, v);
         `chk(v, e & ~w)
         u_hmt_host.wr(8'h4E, 8'hFF);
      end
      // Fan errors: equal and just-over corners; fan 4 cannot be cleared
      fexp = 8'h00;
      for (int i = 0; i < 4; i++) begin
         fan_in = {xs(), xs(), xs(), xs()};
         if (i == 0) begin
            fan_in.limit[0] = 16'hFFFE;
            fan_in.count[0] = 16'hFFFF;
            fan_in.count[1] = fan_in.limit[1];
            fan_in.count[3] = 16'h0100;
            fan_in.limit[3] = 16'h00FF;
         end
         // Passes 2 and 3 sleep: light, then the deepest state
         sleep_state = (i == 2) ? HMT_S1 : (i == 3) ? HMT_S45 : HMT_S0;
         for (int j = 0; j < 4; j++)
            if (i < 2 && fan_in.count[j] > fan_in.limit[j])
               fexp[j] = 1'b1;
         step(3);
         u_hmt_host.rd(8'h4F, v);
         `chk(v, fexp)
         fan_in = '0;
         step(2);
         u_hmt_host.wr(8'h4F, 8'hFF);
         fexp = fexp & 8'h08;
         u_hmt_host.rd(8'h4F, v);
         `chk(v, fexp)
      end
      // Temperatures: raw, faulted and smoothed
      sleep_state = HMT_S0;
      f1 = 8'h00;
      f2 = 8'h00;
      for (int i = 0; i < 6; i++) begin
         w = 8'(xs());
         temp_in = {8'(xs()), 8'(xs()), 8'(xs()), 1'b1, i == 2 || (i > 3 && w[0]),
            i == 2 || (i > 3 && w[1])};
         smooth_ctrl = (i < 3) ? hmt_smooth_s'(8'h00) : hmt_smooth_s'(8'(xs()));
         r1 = temp_in.diode1_fault ? 8'h80 : temp_in.zone1;
         r2 = temp_in.diode2_fault ? 8'h80 : temp_in.zone2;
         f1 = smooth_ctrl.z1_enable ? smooth(f1, r1, smooth_ctrl.z1_shift) : r1;
         f2 = smooth_ctrl.z2_enable ? smooth(f2, r2, smooth_ctrl.z2_shift) : r2;
         ex = '{f1, f2, r1, r2, temp_in.zone3};
         step(1);
         temp_in.valid = 1'b0;
         for (int k = 0; k < 5; k++) begin
            u_hmt_host.rd(TOFS[k], v);
            `chk(v, ex[k])
         end
      end
      // Zone 4 keeps a host byte; a read-only zone ignores one
      w = 8'(xs());
      u_hmt_host.wr(8'h53, w);
      u_hmt_host.rd(8'h53, v);
      `chk(v, w)
      u_hmt_host.wr(8'h52, ~ex[4]);
      u_hmt_host.rd(8'h52, v);
      `chk(v, ex[4])
      print_verdict();
   end
endmodule : testbench

bind hmt_regs hmt_regs_chk #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_chk (.clk(clk),
   .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
   .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .cpu2_throttle_input(cpu2_throttle_input),
   .general_pin(general_pin), .throttle_limit(throttle_limit),
   .input_error_mask(input_error_mask), .smooth_ctrl(smooth_ctrl),
   .sleep_state(sleep_state), .temp_in(temp_in), .fan_in(fan_in), .host_error(host_error));
